// File: rtl/chg_pkg.sv
// Package: register map, field layout, codes and timing of the charger slice
package chg_pkg;
  // Register offsets
  localparam logic [7:0] CHG_OFS_CTRL10 = 8'h12;
  localparam logic [7:0] CHG_OFS_VBAT = 8'h13;
  localparam logic [7:0] CHG_OFS_VSYS = 8'h14;
  localparam logic [7:0] CHG_OFS_TS = 8'h15;
  localparam logic [7:0] CHG_OFS_VBUS = 8'h16;
  localparam logic [7:0] CHG_OFS_ICHG = 8'h17;
  localparam logic [7:0] CHG_OFS_IBUS = 8'h18;
  // Reset values
  localparam logic [7:0] CHG_CTRL_RST = 8'h00;
  localparam logic [7:0] CHG_RES_RST = 8'h00;
  localparam logic [7:0] CHG_ZERO8 = 8'h00;
  // Control register field positions
  localparam int CHG_LVL_HI = 7;
  localparam int CHG_LVL_LO = 6;
  localparam int CHG_DEG_HI = 5;
  localparam int CHG_DEG_LO = 4;
  localparam int CHG_HIZ_BIT = 3;
  localparam int CHG_DET_BIT = 2;
  localparam int CHG_FREQ_BIT = 1;
  // Bits kept through register reset or watchdog (deglitch field); all other fields cleared
  localparam logic [7:0] CHG_CTRL_KEEP = 8'h30;
  // Highest valid result codes
  localparam logic [7:0] CHG_VBAT_MAX = 8'hE8;
  localparam logic [7:0] CHG_TS_MAX = 8'h6F;
  localparam logic [7:0] CHG_IBUS_MAX = 8'h84;
  // Overcurrent levels in mA for codes 0..3
  localparam logic [15:0] CHG_OCP_MA0 = 16'h1770;
  localparam logic [15:0] CHG_OCP_MA1 = 16'h1F40;
  localparam logic [15:0] CHG_OCP_MA2 = 16'h2710;
  localparam logic [15:0] CHG_OCP_MA3 = 16'h2EE0;
  // Timing
  localparam int CHG_CLK_NS = 10;
  localparam int CHG_DEG0_NS = 128000;
  localparam int CHG_DEG1_NS = 256000;
  localparam int CHG_DEG2_NS = 1000000;
  localparam int CHG_DEG3_NS = 2000000;
  localparam int CHG_RATE_NS = 1000000000;
  localparam int CHG_DEG0_CYC = (CHG_DEG0_NS + CHG_CLK_NS - 1) / CHG_CLK_NS;
  localparam int CHG_DEG1_CYC = (CHG_DEG1_NS + CHG_CLK_NS - 1) / CHG_CLK_NS;
  localparam int CHG_DEG2_CYC = (CHG_DEG2_NS + CHG_CLK_NS - 1) / CHG_CLK_NS;
  localparam int CHG_DEG3_CYC = (CHG_DEG3_NS + CHG_CLK_NS - 1) / CHG_CLK_NS;
  localparam int CHG_RATE_CYC = (CHG_RATE_NS + CHG_CLK_NS - 1) / CHG_CLK_NS;
  localparam int CHG_CNT_W = 28;
  // Channel numbers, also index of the per-channel disable bits
  localparam logic [2:0] CHG_CH_IBUS = 3'h0;
  localparam logic [2:0] CHG_CH_ICHG = 3'h1;
  localparam logic [2:0] CHG_CH_VBUS = 3'h2;
  localparam logic [2:0] CHG_CH_VBAT = 3'h3;
  localparam logic [2:0] CHG_CH_VSYS = 3'h4;
  localparam logic [2:0] CHG_CH_TS = 3'h5;
  localparam logic [2:0] CHG_CH_LAST = 3'h5;
  localparam logic [2:0] CHG_CH_ONE = 3'h1;
  // Register port request from the serial slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chg_req_t;
  // Converter result
  typedef struct packed {
    logic done;
    logic [2:0] chan;
    logic [7:0] code;
  } chg_adc_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_PAUSE} chg_seq_t;
endpackage

// File: rtl/chg_regs.sv
// Charger control register and converter result registers with sequencer
`timescale 1ns/100ps
`default_nettype none
module chg_regs
  import chg_pkg::*;
#(
  parameter int DEG0_CYC = CHG_DEG0_CYC,
  parameter int DEG1_CYC = CHG_DEG1_CYC,
  parameter int DEG2_CYC = CHG_DEG2_CYC,
  parameter int DEG3_CYC = CHG_DEG3_CYC,
  parameter int RATE_CYC = CHG_RATE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register port
  input wire chg_req_t req_i,
  output logic [7:0] rdata_o,
  // Reset sources
  input wire logic reg_rst_i,
  input wire logic wdog_expire_i,
  // Battery switch current in mA
  input wire logic [15:0] batsw_current_i,
  output logic batsw_overcurrent_o,
  output logic [1:0] batsw_overcurrent_level_o,
  output logic [1:0] batsw_overcurrent_deglitch_o,
  // Control levels
  output logic input_highz_enable_o,
  output logic usb_detect_enable_o,
  output logic boost_freq_select_o,
  // Conversion control
  input wire logic conversion_go_i,
  input wire logic conversion_rate_select_i,
  input wire logic [5:0] chan_off_i,
  input wire logic battery_below_short_i,
  output logic conversion_go_clear_o,
  output logic conversion_active_o,
  output logic adc_start_o,
  output logic [2:0] adc_chan_o,
  input wire chg_adc_t adc_i
);

  function automatic logic [7:0] clamp_code(input logic [7:0] c,
                                            input logic [7:0] mx);
    clamp_code = (c > mx) ? mx : c;
  endfunction

  function automatic logic [CHG_CNT_W-1:0] to_cnt(input int v);
    to_cnt = CHG_CNT_W'(v);
  endfunction

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] vbat_q, vbat_d, vsys_q, vsys_d, ts_q, ts_d;
  logic [7:0] vbus_q, vbus_d, ichg_q, ichg_d, ibus_q, ibus_d;
  logic [7:0] rdata_q, rdata_d;
  logic ctrl_wr;

  // Control and read path
  always_comb begin
    ctrl_wr = req_i.wr && (req_i.addr == CHG_OFS_CTRL10);
    ctrl_d = ctrl_q;
    if (reg_rst_i || wdog_expire_i) begin
      ctrl_d = ctrl_q & CHG_CTRL_KEEP;
    end else if (ctrl_wr) begin
      ctrl_d = req_i.wdata;
    end
    rdata_d = rdata_q;
    if (req_i.rd) begin
      unique case (req_i.addr)
        CHG_OFS_CTRL10: rdata_d = ctrl_q;
        CHG_OFS_VBAT: rdata_d = vbat_q;
        CHG_OFS_VSYS: rdata_d = vsys_q;
        CHG_OFS_TS: rdata_d = ts_q;
        CHG_OFS_VBUS: rdata_d = vbus_q;
        CHG_OFS_ICHG: rdata_d = ichg_q;
        CHG_OFS_IBUS: rdata_d = ibus_q;
        default: rdata_d = CHG_ZERO8;
      endcase
    end
  end

  // Result capture; reserved codes saturate to the top valid code
  always_comb begin
    vbat_d = vbat_q;
    vsys_d = vsys_q;
    ts_d = ts_q;
    vbus_d = vbus_q;
    ichg_d = ichg_q;
    ibus_d = ibus_q;
    if (adc_i.done) begin
      unique case (adc_i.chan)
        CHG_CH_VBAT: vbat_d = clamp_code(adc_i.code, CHG_VBAT_MAX);
        CHG_CH_VSYS: vsys_d = clamp_code(adc_i.code, CHG_VBAT_MAX);
        CHG_CH_TS: ts_d = clamp_code(adc_i.code, CHG_TS_MAX);
        CHG_CH_VBUS: vbus_d = adc_i.code;
        CHG_CH_ICHG: ichg_d = battery_below_short_i ? CHG_ZERO8 : adc_i.code;
        CHG_CH_IBUS: ibus_d = clamp_code(adc_i.code, CHG_IBUS_MAX);
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= CHG_CTRL_RST;
      rdata_q <= CHG_ZERO8;
      vbat_q <= CHG_RES_RST;
      vsys_q <= CHG_RES_RST;
      ts_q <= CHG_RES_RST;
      vbus_q <= CHG_RES_RST;
      ichg_q <= CHG_RES_RST;
      ibus_q <= CHG_RES_RST;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      vbat_q <= vbat_d;
      vsys_q <= vsys_d;
      ts_q <= ts_d;
      vbus_q <= vbus_d;
      ichg_q <= ichg_d;
      ibus_q <= ibus_d;
    end
  end

  assign rdata_o = rdata_q;
  assign batsw_overcurrent_level_o = ctrl_q[CHG_LVL_HI:CHG_LVL_LO];
  assign batsw_overcurrent_deglitch_o = ctrl_q[CHG_DEG_HI:CHG_DEG_LO];
  assign input_highz_enable_o = ctrl_q[CHG_HIZ_BIT];
  assign usb_detect_enable_o = ctrl_q[CHG_DET_BIT];
  assign boost_freq_select_o = ctrl_q[CHG_FREQ_BIT];

  // Overcurrent deglitch
  logic [15:0] ocp_ma;
  logic [CHG_CNT_W-1:0] deg_lim, deg_q, deg_d;
  logic over, ocp_q, ocp_d;
  always_comb begin
    unique case (ctrl_q[CHG_LVL_HI:CHG_LVL_LO])
      2'h0: ocp_ma = CHG_OCP_MA0;
      2'h1: ocp_ma = CHG_OCP_MA1;
      2'h2: ocp_ma = CHG_OCP_MA2;
      2'h3: ocp_ma = CHG_OCP_MA3;
    endcase
    unique case (ctrl_q[CHG_DEG_HI:CHG_DEG_LO])
      2'h0: deg_lim = to_cnt(DEG0_CYC);
      2'h1: deg_lim = to_cnt(DEG1_CYC);
      2'h2: deg_lim = to_cnt(DEG2_CYC);
      2'h3: deg_lim = to_cnt(DEG3_CYC);
    endcase
    over = batsw_current_i > ocp_ma;
    deg_d = deg_q;
    ocp_d = ocp_q;
    if (!over) begin
      deg_d = '0;
      ocp_d = 1'b0;
    end else if (deg_q >= deg_lim - to_cnt(1)) begin
      ocp_d = 1'b1;
    end else begin
      deg_d = deg_q + to_cnt(1);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      deg_q <= '0;
      ocp_q <= 1'b0;
    end else if (ce_i) begin
      deg_q <= deg_d;
      ocp_q <= ocp_d;
    end
  end
  assign batsw_overcurrent_o = ocp_q;

  // Conversion sequencer
  chg_seq_t st_q, st_d;
  logic [2:0] ch_q, ch_d;
  logic [CHG_CNT_W-1:0] tmr_q, tmr_d;
  logic clr_q, clr_d, start, skip;
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    tmr_d = tmr_q;
    clr_d = 1'b0;
    start = 1'b0;
    skip = chan_off_i[ch_q] && !conversion_rate_select_i;
    unique case (st_q)
      SQ_IDLE: begin
        // Go is ignored in the clear cycle so a stale bit cannot retrigger
        if (conversion_rate_select_i || (conversion_go_i && !clr_q)) begin
          st_d = SQ_ISSUE;
          ch_d = CHG_CH_IBUS;
        end
      end
      SQ_ISSUE, SQ_WAIT: begin
        if (st_q == SQ_ISSUE && !skip) begin
          start = 1'b1;
          st_d = SQ_WAIT;
        end else if (st_q == SQ_ISSUE || adc_i.done) begin
          if (ch_q != CHG_CH_LAST) begin
            ch_d = ch_q + CHG_CH_ONE;
            st_d = SQ_ISSUE;
          end else if (conversion_rate_select_i) begin
            st_d = SQ_PAUSE;
            tmr_d = '0;
          end else begin
            st_d = SQ_IDLE;
            clr_d = 1'b1;
          end
        end
      end
      SQ_PAUSE: begin
        if (!conversion_rate_select_i) begin
          st_d = SQ_IDLE;
        end else if (tmr_q >= to_cnt(RATE_CYC) - to_cnt(1)) begin
          st_d = SQ_ISSUE;
          ch_d = CHG_CH_IBUS;
        end else begin
          tmr_d = tmr_q + to_cnt(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= SQ_IDLE;
      ch_q <= CHG_CH_IBUS;
      tmr_q <= '0;
      clr_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      ch_q <= ch_d;
      tmr_q <= tmr_d;
      clr_q <= clr_d;
    end
  end

  assign adc_start_o = start && ce_i;
  assign adc_chan_o = ch_q;
  assign conversion_go_clear_o = clr_q;
  assign conversion_active_o = (st_q == SQ_ISSUE) || (st_q == SQ_WAIT);

  // Checks
  a_ctrl_rst_dflt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && (reg_rst_i || wdog_expire_i) |=>
    ctrl_q[CHG_LVL_HI:CHG_LVL_LO] == 2'h0 && ctrl_q[3:0] == 4'h0)
    else $error("control fields not defaulted");
  a_highz_write: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && ctrl_wr && !reg_rst_i && !wdog_expire_i |=>
    input_highz_enable_o == $past(req_i.wdata[CHG_HIZ_BIT]))
    else $error("high-impedance output wrong after write");
  a_detect_write: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && ctrl_wr && !reg_rst_i && !wdog_expire_i |=>
    usb_detect_enable_o == $past(req_i.wdata[CHG_DET_BIT]))
    else $error("detection enable wrong after write");
  a_freq_write: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && ctrl_wr && !reg_rst_i && !wdog_expire_i |=>
    boost_freq_select_o == $past(req_i.wdata[CHG_FREQ_BIT]))
    else $error("boost frequency wrong after write");
  a_ocp_cause: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(batsw_overcurrent_o) |-> $past(over) && $past(over, 2))
    else $error("overcurrent raised without persistent excess");
  a_vbat_range: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && adc_i.done && adc_i.chan == CHG_CH_VBAT |=>
    vbat_q == clamp_code($past(adc_i.code), CHG_VBAT_MAX))
    else $error("battery result wrong");
  a_vsys_range: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && adc_i.done && adc_i.chan == CHG_CH_VSYS |=>
    vsys_q <= CHG_VBAT_MAX)
    else $error("system result above range");
  a_ts_range: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && adc_i.done && adc_i.chan == CHG_CH_TS |=>
    ts_q <= CHG_TS_MAX)
    else $error("thermistor result above range");
  a_ichg_short: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && adc_i.done && adc_i.chan == CHG_CH_ICHG
    && battery_below_short_i |=> ichg_q == CHG_ZERO8)
    else $error("charge current not zero below short");
  a_ibus_range: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ce_i && adc_i.done && adc_i.chan == CHG_CH_IBUS |=>
    ibus_q <= CHG_IBUS_MAX)
    else $error("input current above range");
  a_skip_chan: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    adc_start_o |-> !(chan_off_i[adc_chan_o]
    && !conversion_rate_select_i))
    else $error("disabled channel started");
  a_go_clear: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    conversion_go_clear_o |-> !conversion_active_o
    && $past(conversion_active_o))
    else $error("go cleared while not finishing");
  c_ocp_fire: cover property (@(posedge mclk_i) $rose(batsw_overcurrent_o));
  c_oneshot_done: cover property (@(posedge mclk_i) conversion_go_clear_o);
  c_pause: cover property (@(posedge mclk_i) st_q == SQ_PAUSE);
  c_restart: cover property (@(posedge mclk_i)
    st_q == SQ_PAUSE ##1 st_q == SQ_ISSUE);

endmodule
`default_nettype wire

// File: testbench/chg_adc_model.sv
// Behavioural converter that answers each start with a per-channel code
`timescale 1ns/100ps
`default_nettype none
module chg_adc_model
  import chg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Start request from the sequencer
  input wire logic adc_start_i,
  input wire logic [2:0] adc_chan_i,
  // Codes per channel and answer delay
  input wire logic [47:0] codes_i,
  input wire logic [3:0] lat_i,
  output var chg_adc_t adc_o
);
  logic busy_q;
  logic [2:0] chan_q;
  logic [3:0] cnt_q;
  // Idle lines flip every cycle so a stale code is never read as fresh
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      chan_q <= 3'h0;
      cnt_q <= 4'h0;
      adc_o <= '0;
    end else begin
      if (adc_start_i) begin
        adc_o <= {1'b0, ~adc_o.chan, ~adc_o.code};
        busy_q <= 1'b1;
        chan_q <= adc_chan_i;
        cnt_q <= lat_i;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        adc_o <= {1'b1, chan_q, codes_i[{chan_q, 3'b000} +: 8]};
      end else begin
        adc_o <= {1'b0, ~adc_o.chan, ~adc_o.code};
        if (busy_q) begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_chg_regs.sv
// Self-checking bench for the charger register slice
`timescale 1ns/100ps
`default_nettype none
module test_chg_regs;
  import chg_pkg::*;
  localparam logic [47:0] ADDRS = {8'h15, 8'h14, 8'h13, 8'h16, 8'h17, 8'h18};
  localparam int PAUSE_CYC = 50;
  logic mclk_i, nrst_i, reg_rst, wdog, go, rate, below, oc, goclr, active;
  logic start, hiz, det, freq, ce;
  logic [1:0] lvl, deg;
  logic [2:0] chan;
  logic [3:0] lat;
  logic [5:0] off;
  logic [7:0] rdata;
  logic [15:0] cur;
  logic [47:0] codes;
  chg_req_t req;
  chg_adc_t adc;
  int n_mismatch = 0;
  int comparisons = 0;

  // Short deglitch and pause counts keep the run brief
  chg_regs #(.DEG0_CYC(4), .DEG1_CYC(8), .DEG2_CYC(16), .DEG3_CYC(32),
    .RATE_CYC(PAUSE_CYC)) chg_regs_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .req_i(req),
    .rdata_o(rdata), .reg_rst_i(reg_rst), .wdog_expire_i(wdog),
    .batsw_current_i(cur), .batsw_overcurrent_o(oc),
    .batsw_overcurrent_level_o(lvl), .batsw_overcurrent_deglitch_o(deg),
    .input_highz_enable_o(hiz), .usb_detect_enable_o(det),
    .boost_freq_select_o(freq), .conversion_go_i(go),
    .conversion_rate_select_i(rate), .chan_off_i(off),
    .battery_below_short_i(below), .conversion_go_clear_o(goclr),
    .conversion_active_o(active), .adc_start_o(start), .adc_chan_o(chan),
    .adc_i(adc));
  chg_adc_model chg_adc_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .adc_start_i(start), .adc_chan_i(chan), .codes_i(codes), .lat_i(lat),
    .adc_o(adc));

  always #5 mclk_i = ~mclk_i;

  task automatic final_report();
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    final_report();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= {1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    req <= '0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    req <= '0;
    @(posedge mclk_i);
    check(rdata, exp);
  endtask

  task automatic rdall(input logic [47:0] exp);
    int i;
    for (i = 0; i < 6; i++) begin
      rd(ADDRS[i*8 +: 8], exp[i*8 +: 8]);
    end
  endtask

  task automatic reset_values();
    int i;
    for (i = 0; i < 7; i++) begin
      rd(8'h12 + 8'(i), 8'h00);
    end
    check(8'({lvl, deg, hiz, det, freq}), 8'h00);
  endtask

  task automatic control();
    int k;
    for (k = 1; k < 4; k++) begin
      wr(8'h12, 8'h01 << k);
      check(8'({lvl, deg, hiz, det, freq}), 8'h01 << (k - 1));
    end
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'hFF);
    @(posedge mclk_i);
    reg_rst <= 1'b1;
    @(posedge mclk_i);
    reg_rst <= 1'b0;
    rd(8'h12, 8'h30);
    wr(8'h12, 8'hEF);
    @(posedge mclk_i);
    wdog <= 1'b1;
    @(posedge mclk_i);
    wdog <= 1'b0;
    rd(8'h12, 8'h20);
    wr(8'h13, 8'h55);
    rd(8'h13, 8'h00);
    rd(8'h1F, 8'h00);
  endtask

  // Clock enable low must hold the control register against a write
  task automatic freeze();
    @(posedge mclk_i);
    ce <= 1'b0;
    wr(8'h12, 8'h0E);
    check(8'({lvl, deg, hiz, det, freq}), 8'h10);
    ce <= 1'b1;
    rd(8'h12, 8'h20);
  endtask

  // Plays the outside go bit: set, then cleared on the clear pulse
  task automatic oneshot(input logic [5:0] o);
    int i;
    @(posedge mclk_i);
    off <= o;
    go <= 1'b1;
    for (i = 0; i < 400; i++) begin
      @(posedge mclk_i);
      if (i == 1) check(8'(active), 8'h01);
      if (goclr === 1'b1) break;
    end
    go <= 1'b0;
    if (i == 400) timeout();
    check(8'(active), 8'h00);
  endtask

  // Two passes: the pause between them is counted, new codes land in pass two
  task automatic continuous();
    int i;
    int gap;
    logic seen;
    seen = 1'b0;
    gap = 0;
    @(posedge mclk_i);
    rate <= 1'b1;
    for (i = 0; i < 500; i++) begin
      @(posedge mclk_i);
      if (seen && active === 1'b0) gap++;
      if (gap == 1) codes <= {6{8'h33}};
      if (gap > 0 && active === 1'b1) break;
      if (active === 1'b1) seen = 1'b1;
    end
    if (i == 500) timeout();
    check(8'(gap), 8'(PAUSE_CYC));
    for (i = 0; i < 500; i++) begin
      @(posedge mclk_i);
      if (active === 1'b0) break;
    end
    rate <= 1'b0;
    if (i == 500) timeout();
  endtask

  task automatic ocp(input logic [7:0] c, input logic [15:0] lim, input int n);
    wr(8'h12, c);
    check(8'({lvl, deg}), c >> 4);
    cur <= lim;
    repeat (n + 6) @(posedge mclk_i);
    check(8'(oc), 8'h00);
    cur <= lim + 16'h0001;
    repeat (n) @(posedge mclk_i);
    check(8'(oc), 8'h00);
    @(posedge mclk_i);
    check(8'(oc), 8'h01);
    cur <= lim;
    repeat (2) @(posedge mclk_i);
    check(8'(oc), 8'h00);
  endtask

  initial begin
    mclk_i = 1'b0;
    nrst_i = 1'b0;
    req = '0;
    reg_rst = 1'b0;
    wdog = 1'b0;
    ce = 1'b1;
    go = 1'b0;
    rate = 1'b0;
    below = 1'b0;
    off = 6'h00;
    cur = 16'h0000;
    codes = 48'h0;
    lat = 4'h0;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    reset_values();
    control();
    freeze();
    codes <= {8'h70, 8'hE8, 8'hE9, 8'hFF, 8'hFF, 8'h85};
    lat <= 4'h3;
    oneshot(6'h00);
    rdall({8'h6F, 8'hE8, 8'hE8, 8'hFF, 8'hFF, 8'h84});
    codes <= {6{8'h11}};
    lat <= 4'h0;
    below <= 1'b1;
    oneshot(6'h08);
    rdall({8'h11, 8'h11, 8'hE8, 8'h11, 8'h00, 8'h11});
    codes <= {6{8'h22}};
    below <= 1'b0;
    continuous();
    rdall({6{8'h33}});
    ocp(8'h00, 16'h1770, 4);
    ocp(8'h50, 16'h1F40, 8);
    ocp(8'hA0, 16'h2710, 16);
    ocp(8'hF0, 16'h2EE0, 32);
    final_report();
  end
endmodule
`default_nettype wire
